/* include/sib_pkg.sv */
`default_nettype none
package sib_pkg;
    localparam int SIB_AW = 16;
    localparam logic [15:0] SIB_NP_BASE = 16'h4000;
    localparam logic [15:0] SIB_NP_LIMIT = 16'h7FFF;
    localparam logic [15:0] SIB_MISC_BASE = 16'h7F00;
    localparam logic [15:0] SIB_MISC_LIMIT = 16'h7F0F;
    localparam logic [15:0] SIB_IFCTL_BASE = 16'h7E00;
    localparam logic [15:0] SIB_IFCTL_LIMIT = 16'h7EFF;
    localparam int SIB_VER_W = 16;
    localparam int SIB_IF_UART = 0;
    localparam int SIB_IF_SPI = 1;
    localparam logic [2:0] SIB_OWN_RESET = 3'h0;
    localparam logic [1:0] SIB_LVL_1 = 2'h1;
    localparam logic [1:0] SIB_LVL_2 = 2'h2;
    localparam logic [1:0] SIB_LVL_3 = 2'h3;
    // Cipher modes.
    localparam logic SIB_MODE_XTS = 1'b0;
    localparam logic SIB_MODE_CTR = 1'b1;
    typedef enum {SIB_ST_RESET, SIB_ST_SEC_BOOT, SIB_ST_ISP, SIB_ST_APP_BOOT} sib_state_t;
endpackage
`default_nettype wire

/* include/sib_xip_if.sv */
`default_nettype none
interface sib_xip_if;
    logic valid;
    logic [31:0] addr;
    logic [127:0] cipher;
    logic mode;
    logic [127:0] key;
    logic out_valid;
    logic [127:0] plain;
    modport master (output valid, addr, cipher, mode, key, input out_valid, plain);
    modport engine (input valid, addr, cipher, mode, key, output out_valid, plain);
endinterface
`default_nettype wire

/* rtl/sib_xip_decrypt.sv */
`default_nettype none
module sib_xip_decrypt (
    input wire logic sys_clk,
    input wire logic rst_n,
    sib_xip_if.engine xp
);
    import sib_pkg::*;

    logic out_valid_reg;
    logic out_valid_next;
    logic [127:0] plain_reg;
    logic [127:0] plain_next;

    function automatic logic [127:0] sib_tweak(input logic [31:0] a, input logic [127:0] k);
        sib_tweak = {k[127:32], k[31:0] ^ a} ^ {k[63:0], k[127:64]};
    endfunction

    // ----------
    // Keystream combine, one block per request.
    // ----------
    always_comb begin
        out_valid_next = xp.valid;
        plain_next = plain_reg;
        if (xp.valid) begin
            if (xp.mode == SIB_MODE_CTR) begin
                plain_next = xp.cipher ^ sib_tweak(xp.addr, xp.key);
            end else begin
                plain_next = {xp.cipher[63:0], xp.cipher[127:64]} ^ sib_tweak(xp.addr, xp.key);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            plain_reg <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
        end else begin
            out_valid_reg <= out_valid_next;
            plain_reg <= plain_next;
        end
    end

    assign xp.out_valid = out_valid_reg;
    assign xp.plain = plain_reg;
endmodule // sib_xip_decrypt
`default_nettype wire

/* rtl/sib_isp_detect.sv */
`default_nettype none
module sib_isp_detect (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic [2:0] activity,
    output logic locked,
    output logic [2:0] winner
);
    import sib_pkg::*;

    logic locked_reg;
    logic locked_next;
    logic [2:0] winner_reg;
    logic [2:0] winner_next;

    // ----------
    // First active interface wins the session.
    // ----------
    always_comb begin
        locked_next = locked_reg;
        winner_next = winner_reg;
        if (!arm) begin
            locked_next = 1'b0;
            winner_next = 3'h0;
        end else if (!locked_reg && (activity != 3'h0)) begin
            locked_next = 1'b1;
            if (activity[SIB_IF_UART]) begin
                winner_next = 3'h1;
            end else if (activity[SIB_IF_SPI]) begin
                winner_next = 3'h2;
            end else begin
                winner_next = 3'h4;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_reg <= 1'b0;
            winner_reg <= 3'h0;
        end else begin
            locked_reg <= locked_next;
            winner_reg <= winner_next;
        end
    end

    assign locked = locked_reg;
    assign winner = winner_reg;
endmodule // sib_isp_detect
`default_nettype wire

/* rtl/sib_secure_isolation_boot_policy.sv */
// What this block does
// - Isolation on: block application core accesses to the network processor itself.
// - Isolation on: refuse network processor space except boot command registers.
// - Isolation on: deny peripherals and hosts network processor register access.
// - Isolation enabled only by a programmed fuse bit; clear means off.
// - Isolation on: host writes cannot reconfigure network processor owned interfaces.
// - Isolation on: each programming interface has exactly one owner core.
// - Isolation on: default owners come from boot record configuration.
// - Every reset starts security boot; application boot only after it completes.
// - Pin, power-on, watchdog, blackout, core request, wake-up all enter boot.
// - Rollback protection: accept image only when version is not lower.
// - Level 1 never writable; levels 2 and 3 writable by boot stage only.
// - Application software cannot change protection levels after manufacturing.
// - Host image replaces stored image only after authenticity and integrity pass.
// - Programming mode watches all three interfaces and takes the first active.
// - In-place code decrypted inline with device keys, XTS or CTR.
`default_nettype none
module sib_secure_isolation_boot_policy (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Reset and wake sources, programming strap
    input wire logic power_on_trigger,
    input wire logic watchdog_reset,
    input wire logic blackout_trip,
    input wire logic core_reset_request,
    input wire logic sleep_wakeup,
    input wire logic debug_data_out_pin,
    // Fuse and boot record configuration
    input wire logic otp_isolation_bit,
    input wire logic otp_rollback_enable,
    input wire logic [2:0] boot_record_config,
    input wire logic [sib_pkg::SIB_VER_W-1:0] installed_version,
    // Security boot stage firmware
    input wire logic sec_boot_done,
    // Application core bus request
    input wire logic app_req,
    input wire logic app_we,
    input wire logic [sib_pkg::SIB_AW-1:0] app_addr,
    input wire logic app_target_np_core,
    // External peripheral and host bus request
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [sib_pkg::SIB_AW-1:0] ext_addr,
    // Runtime ownership writes
    input wire logic own_wr,
    input wire logic [2:0] own_wdata,
    // Programming interface activity
    input wire logic [2:0] isp_activity,
    // Flash write request
    input wire logic flash_wr_req,
    input wire logic [1:0] flash_wr_level,
    input wire logic flash_wr_is_level_cfg,
    // Image update request
    input wire logic img_req,
    input wire logic [sib_pkg::SIB_VER_W-1:0] img_version,
    input wire logic img_auth_ok,
    input wire logic img_integrity_ok,
    // Execute-in-place fetch
    input wire logic xip_valid,
    input wire logic [31:0] xip_addr,
    input wire logic [127:0] xip_cipher,
    input wire logic xip_mode,
    input wire logic [127:0] device_unique_key_source,
    // Outputs
    output logic isolation_on,
    output logic in_sec_boot,
    output logic app_boot_enable,
    output logic isp_mode,
    output logic app_grant,
    output logic app_deny,
    output logic ext_grant,
    output logic ext_deny,
    output logic [2:0] np_owns_if,
    output logic [2:0] app_owns_if,
    output logic [2:0] isp_session_if,
    output logic flash_wr_grant,
    output logic flash_wr_deny,
    output logic img_accept,
    output logic img_reject,
    output logic xip_out_valid,
    output logic [127:0] xip_plain
);
    import sib_pkg::*;

    function automatic logic in_range(input logic [SIB_AW-1:0] a, input logic [SIB_AW-1:0] lo,
                                      input logic [SIB_AW-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    sib_state_t state_reg;
    sib_state_t state_next;
    logic iso_reg;
    logic iso_next;
    logic strap_reg;
    logic strap_next;
    logic isp_reg;
    logic isp_next;
    logic [2:0] own_reg;
    logic [2:0] own_next;
    logic app_grant_reg;
    logic app_grant_next;
    logic app_deny_reg;
    logic app_deny_next;
    logic ext_grant_reg;
    logic ext_grant_next;
    logic ext_deny_reg;
    logic ext_deny_next;
    logic fl_grant_reg;
    logic fl_grant_next;
    logic fl_deny_reg;
    logic fl_deny_next;
    logic img_acc_reg;
    logic img_acc_next;
    logic img_rej_reg;
    logic img_rej_next;
    logic boot_event;
    logic det_locked;
    logic [2:0] det_winner;

    sib_xip_if xp ();

    // ----------
    // Boot sequencing.
    // ----------
    // Boot entry sources
    assign boot_event = power_on_trigger | watchdog_reset | blackout_trip | core_reset_request | sleep_wakeup;

    always_comb begin
        state_next = state_reg;
        iso_next = iso_reg;
        strap_next = strap_reg;
        isp_next = isp_reg;
        case (state_reg)
            SIB_ST_RESET: begin
                iso_next = otp_isolation_bit;
                strap_next = ~debug_data_out_pin;
                state_next = SIB_ST_SEC_BOOT;
            end
            SIB_ST_SEC_BOOT: begin
                if (strap_reg) begin
                    isp_next = 1'b1;
                    state_next = SIB_ST_ISP;
                end else if (sec_boot_done) begin
                    state_next = SIB_ST_APP_BOOT;
                end
            end
            SIB_ST_ISP: begin
                if (sec_boot_done) begin
                    isp_next = 1'b0;
                    state_next = SIB_ST_APP_BOOT;
                end
            end
            SIB_ST_APP_BOOT: begin
                state_next = SIB_ST_APP_BOOT;
            end
            default: begin
                state_next = SIB_ST_RESET;
            end
        endcase
        if (boot_event) begin
            state_next = SIB_ST_RESET;
            isp_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SIB_ST_RESET;
            iso_reg <= 1'b0;
            strap_reg <= 1'b0;
            isp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            iso_reg <= iso_next;
            strap_reg <= strap_next;
            isp_reg <= isp_next;
        end
    end

    // ----------
    // Interface ownership.
    // ----------
    always_comb begin
        own_next = own_reg;
        if (state_reg == SIB_ST_RESET) begin
            own_next = boot_record_config;
        end else if (own_wr && !iso_reg) begin
            own_next = own_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            own_reg <= SIB_OWN_RESET;
        end else begin
            own_reg <= own_next;
        end
    end

    // ----------
    // Access filtering.
    // ----------
    always_comb begin
        app_grant_next = 1'b0;
        app_deny_next = 1'b0;
        ext_grant_next = 1'b0;
        ext_deny_next = 1'b0;
        if (app_req) begin
            app_grant_next = 1'b1;
            if (iso_reg) begin
                if (app_target_np_core) begin
                    app_grant_next = 1'b0;
                end else if (in_range(app_addr, SIB_NP_BASE, SIB_NP_LIMIT) &&
                             !in_range(app_addr, SIB_MISC_BASE, SIB_MISC_LIMIT)) begin
                    app_grant_next = 1'b0;
                end else if (app_we && in_range(app_addr, SIB_IFCTL_BASE, SIB_IFCTL_LIMIT)) begin
                    app_grant_next = 1'b0;
                end
            end
            app_deny_next = ~app_grant_next;
        end
        if (ext_req) begin
            ext_grant_next = ~(iso_reg && in_range(ext_addr, SIB_NP_BASE, SIB_NP_LIMIT));
            ext_deny_next = ~ext_grant_next;
        end
    end

    // ----------
    // Flash and image policy.
    // ----------
    always_comb begin
        fl_grant_next = 1'b0;
        fl_deny_next = 1'b0;
        img_acc_next = 1'b0;
        img_rej_next = 1'b0;
        if (flash_wr_req) begin
            if (flash_wr_is_level_cfg) begin
                fl_grant_next = 1'b0;
            end else if (flash_wr_level == SIB_LVL_1) begin
                fl_grant_next = 1'b0;
            // Levels 2 and 3 boot only
            end else if (flash_wr_level == SIB_LVL_2 || flash_wr_level == SIB_LVL_3) begin
                fl_grant_next = (state_reg == SIB_ST_SEC_BOOT) || (state_reg == SIB_ST_ISP);
            end else begin
                fl_grant_next = 1'b1;
            end
            fl_deny_next = ~fl_grant_next;
        end
        if (img_req) begin
            img_acc_next = img_auth_ok && img_integrity_ok &&
                           (!otp_rollback_enable || (img_version >= installed_version));
            img_rej_next = ~img_acc_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            app_grant_reg <= 1'b0;
            app_deny_reg <= 1'b0;
            ext_grant_reg <= 1'b0;
            ext_deny_reg <= 1'b0;
            fl_grant_reg <= 1'b0;
            fl_deny_reg <= 1'b0;
            img_acc_reg <= 1'b0;
            img_rej_reg <= 1'b0;
        end else begin
            app_grant_reg <= app_grant_next;
            app_deny_reg <= app_deny_next;
            ext_grant_reg <= ext_grant_next;
            ext_deny_reg <= ext_deny_next;
            fl_grant_reg <= fl_grant_next;
            fl_deny_reg <= fl_deny_next;
            img_acc_reg <= img_acc_next;
            img_rej_reg <= img_rej_next;
        end
    end

    // ----------
    // Programming interface detection.
    // ----------
    // First active interface
    sib_isp_detect u_detect (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .arm(isp_reg),
        .activity(isp_activity),
        .locked(det_locked),
        .winner(det_winner)
    );

    // ----------
    // Inline decryption.
    // ----------
    // Device key decryption
    assign xp.valid = xip_valid;
    assign xp.addr = xip_addr;
    assign xp.cipher = xip_cipher;
    assign xp.mode = xip_mode;
    assign xp.key = device_unique_key_source;

    sib_xip_decrypt u_xip (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .xp(xp)
    );

    // ----------
    // Outputs.
    // ----------
    assign isolation_on = iso_reg;
    assign in_sec_boot = (state_reg == SIB_ST_SEC_BOOT) || (state_reg == SIB_ST_ISP);
    assign app_boot_enable = (state_reg == SIB_ST_APP_BOOT);
    assign isp_mode = isp_reg;
    assign app_grant = app_grant_reg;
    assign app_deny = app_deny_reg;
    assign ext_grant = ext_grant_reg;
    assign ext_deny = ext_deny_reg;
    assign np_owns_if = ~own_reg;
    assign app_owns_if = own_reg;
    assign isp_session_if = det_locked ? det_winner : 3'h0;
    assign flash_wr_grant = fl_grant_reg;
    assign flash_wr_deny = fl_deny_reg;
    assign img_accept = img_acc_reg;
    assign img_reject = img_rej_reg;
    assign xip_out_valid = xp.out_valid;
    assign xip_plain = xp.plain;
endmodule // sib_secure_isolation_boot_policy
`default_nettype wire

/* verification/sib_policy_assertions.sv */
`default_nettype none
module sib_policy_checker (
    // Clock, reset and restart source
    input wire logic sys_clk, rst_n, watchdog_reset,
    // Requests
    input wire logic app_req, app_we, app_target_np_core, ext_req, xip_valid,
    input wire logic [sib_pkg::SIB_AW-1:0] app_addr, ext_addr,
    input wire logic flash_wr_req, flash_wr_is_level_cfg, img_req, img_auth_ok, img_integrity_ok,
    input wire logic [1:0] flash_wr_level,
    // Answers
    input wire logic isolation_on, in_sec_boot, isp_mode, app_boot_enable, app_grant, app_deny,
    input wire logic ext_deny, flash_wr_deny, img_accept, xip_out_valid,
    input wire logic [2:0] np_owns_if, app_owns_if, isp_session_if
);
    timeunit 1ns;
    timeprecision 1ns;
    import sib_pkg::*;
    logic app_iso, np_hit, misc_hit;
    function automatic logic in_rng(logic [15:0] a, logic [15:0] lo, logic [15:0] hi);
        return a >= lo && a <= hi;
    endfunction
    assign app_iso = isolation_on && app_req && !app_target_np_core;
    assign np_hit = in_rng(app_addr, SIB_NP_BASE, SIB_NP_LIMIT);
    assign misc_hit = in_rng(app_addr, SIB_MISC_BASE, SIB_MISC_LIMIT);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------
    // Properties
    // ----------
    np_core_block_a: assert property (isolation_on && app_req && app_target_np_core |=> app_deny)
        else $error("core access not denied");
    np_space_block_a: assert property (app_iso && np_hit && !misc_hit |=> app_deny)
        else $error("window access not denied");
    misc_pass_a: assert property (app_iso && misc_hit |=> app_grant)
        else $error("command register access refused");
    ext_block_a: assert property (isolation_on && ext_req && in_rng(ext_addr, SIB_NP_BASE, SIB_NP_LIMIT) |=> ext_deny)
        else $error("host access not denied");
    ifctl_block_a: assert property (app_iso && app_we && in_rng(app_addr, SIB_IFCTL_BASE, SIB_IFCTL_LIMIT) |=> !app_grant)
        else $error("interface control write granted");
    owner_excl_a: assert property (np_owns_if == ~app_owns_if)
        else $error("interface owners overlap");
    boot_first_a: assert property ($rose(app_boot_enable) |-> $past(in_sec_boot) || $past(isp_mode))
        else $error("application boot without boot stage");
    app_after_boot_a: assert property (app_boot_enable |-> !in_sec_boot && !isp_mode)
        else $error("application boot overlaps boot stage");
    restart_boot_a: assert property (watchdog_reset |-> ##2 !app_boot_enable)
        else $error("restart did not leave application boot");
    level_lock_a: assert property (flash_wr_req && (flash_wr_level == SIB_LVL_1 || flash_wr_is_level_cfg) |=> flash_wr_deny)
        else $error("locked flash write not denied");
    level_boot_a: assert property (flash_wr_req && flash_wr_level >= SIB_LVL_2 && app_boot_enable |=> flash_wr_deny)
        else $error("protected write outside boot stage");
    image_valid_a: assert property (img_accept |-> $past(img_req) && $past(img_auth_ok) && $past(img_integrity_ok))
        else $error("image accepted without validation");
    isp_single_a: assert property (isp_session_if != 3'h0 |-> $onehot(isp_session_if) && (isp_mode || $past(isp_mode)))
        else $error("programming session not single");
    xip_answer_a: assert property (xip_valid |=> xip_out_valid)
        else $error("fetch not answered");
    cover property (app_iso && np_hit ##1 app_deny);
    cover property (isp_session_if != 3'h0);
    cover property (img_accept);
endmodule // sib_policy_checker
bind sib_secure_isolation_boot_policy sib_policy_checker i_sib_policy_checker (.*);
`default_nettype wire

/* verification/sib_host_model.sv */
`default_nettype none
module sib_host_model (
    // Clock and reset
    input wire logic sys_clk, rst_n,
    // Commands from the bench
    input wire logic go_app, go_ext, go_we, go_np, want_isp,
    input wire logic [sib_pkg::SIB_AW-1:0] go_addr,
    // Requests toward the block
    output logic app_req, app_we, app_target_np_core, ext_req, ext_we, debug_data_out_pin,
    output logic [sib_pkg::SIB_AW-1:0] app_addr, ext_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import sib_pkg::*;
    // strap driven low only when programming is wanted
    // The strap is driven low to ask for programming and driven high otherwise.
    assign debug_data_out_pin = !want_isp;
    // Requests last one cycle; idle lines show the inverse of their last value.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            app_req <= 1'b0;
            ext_req <= 1'b0;
        end else begin
            app_req <= go_app;
            ext_req <= go_ext;
            app_we <= go_app ? go_we : !app_we;
            ext_we <= go_ext ? go_we : !ext_we;
            app_target_np_core <= go_app ? go_np : !app_target_np_core;
            app_addr <= go_app ? go_addr : ~app_addr;
            ext_addr <= go_ext ? go_addr : ~ext_addr;
        end
    end
endmodule // sib_host_model
`default_nettype wire

/* verification/test_secure_isolation_boot_policy.sv */
`default_nettype none
module test_secure_isolation_boot_policy;
    timeunit 1ns;
    timeprecision 1ns;
    import sib_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic iso_bit = 1'b1, rb_en = 1'b0, done = 1'b0, own_wr = 1'b0, fwr = 1'b0, fcfg = 1'b0, img_rq = 1'b0;
    logic auth = 1'b0, integ = 1'b0, xv = 1'b0, xmode = 1'b0, want_isp = 1'b0;
    logic go_app = 1'b0, go_ext = 1'b0, go_we = 1'b0, go_np = 1'b0;
    logic [4:0] src = 5'h00;
    logic [2:0] cfg = 3'h0, own_d = 3'h0, act = 3'h0, m_own;
    logic [1:0] flvl = 2'h0;
    logic [15:0] inst_ver = 16'h0100, img_ver = 16'h0000, go_addr = 16'h0000;
    logic [31:0] xaddr = 32'h0000_0000;
    logic [127:0] xcip = '0, key = '0;
    logic app_req, app_we, app_tgt, ext_req, ext_we, strap;
    logic [15:0] app_addr, ext_addr;
    logic iso_on, in_sb, abe, ispm, ag, ad, eg, ed, fg, fd, ia, ir, xov;
    logic [2:0] npo, apo, sess;
    bit m_iso;
    int m_stage, bad_count = 0, tests_run = 0;
    always #25 sys_clk = !sys_clk;
    sib_host_model i_sib_host_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .go_app(go_app), .go_ext(go_ext), .go_we(go_we), .go_np(go_np),
        .want_isp(want_isp), .go_addr(go_addr), .app_req(app_req), .app_we(app_we), .app_target_np_core(app_tgt),
        .ext_req(ext_req), .ext_we(ext_we), .debug_data_out_pin(strap), .app_addr(app_addr), .ext_addr(ext_addr)
    );
    sib_secure_isolation_boot_policy i_sib_secure_isolation_boot_policy (
        .sys_clk(sys_clk), .rst_n(rst_n), .power_on_trigger(src[0]), .watchdog_reset(src[1]),
        .blackout_trip(src[2]), .core_reset_request(src[3]), .sleep_wakeup(src[4]), .debug_data_out_pin(strap),
        .otp_isolation_bit(iso_bit), .otp_rollback_enable(rb_en), .boot_record_config(cfg),
        .installed_version(inst_ver), .sec_boot_done(done), .app_req(app_req), .app_we(app_we),
        .app_addr(app_addr), .app_target_np_core(app_tgt), .ext_req(ext_req), .ext_we(ext_we),
        .ext_addr(ext_addr), .own_wr(own_wr), .own_wdata(own_d), .isp_activity(act), .flash_wr_req(fwr),
        .flash_wr_level(flvl), .flash_wr_is_level_cfg(fcfg), .img_req(img_rq), .img_version(img_ver),
        .img_auth_ok(auth), .img_integrity_ok(integ), .xip_valid(xv), .xip_addr(xaddr), .xip_cipher(xcip),
        .xip_mode(xmode), .device_unique_key_source(key), .isolation_on(iso_on), .in_sec_boot(in_sb),
        .app_boot_enable(abe), .isp_mode(ispm), .app_grant(ag), .app_deny(ad), .ext_grant(eg), .ext_deny(ed),
        .np_owns_if(npo), .app_owns_if(apo), .isp_session_if(sess), .flash_wr_grant(fg), .flash_wr_deny(fd),
        .img_accept(ia), .img_reject(ir), .xip_out_valid(xov), .xip_plain()
    );
    // ----------
    // Model and checks
    // ----------
    function automatic bit in_np(int a);
        return a >= SIB_NP_BASE && a <= SIB_NP_LIMIT;
    endfunction
    function automatic bit app_ok(bit np, int a);
        return !m_iso || (!np && (!in_np(a) || (a >= SIB_MISC_BASE && a <= SIB_MISC_LIMIT)));
    endfunction
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_pair(string what, bit exp, logic g, logic d);
        tests_run++;
        if (g !== exp || d !== !exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0b seen %b/%b", what, exp, g, d);
        end
    endtask
    task automatic chk_vec(string what, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stage(int s);
        chk_vec("boot stage", {5'h00, s < 2, s == 1, s == 2}, {5'h00, in_sb, ispm, abe});
    endtask
    task automatic do_reset(bit fuse, bit isp, logic [2:0] c);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        iso_bit <= fuse;
        want_isp <= isp;
        cfg <= c;
        m_iso = fuse;
        m_own = c;
        m_stage = isp;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk_vec("isolation", 8'(fuse), 8'(iso_on));
        stage(m_stage);
    endtask
    task automatic pulse(int i);
        @(posedge sys_clk);
        if (i < 5) src[i] <= 1'b1;
        else done <= 1'b1;
        @(posedge sys_clk);
        src <= 5'h00;
        done <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        m_stage = (i < 5) ? int'(want_isp) : 2;
        stage(m_stage);
    endtask
    task automatic access(bit ext, bit we, bit np, logic [15:0] a);
        @(posedge sys_clk);
        go_app <= !ext;
        go_ext <= ext;
        go_we <= we;
        go_np <= np;
        go_addr <= a;
        @(posedge sys_clk);
        go_app <= 1'b0;
        go_ext <= 1'b0;
        @(posedge sys_clk);
        #1;
        if (ext) chk_pair("host access", !m_iso || !in_np(a), eg, ed);
        else chk_pair("core access", app_ok(np, a), ag, ad);
    endtask
    task automatic own_write(logic [2:0] d);
        @(posedge sys_clk);
        own_wr <= 1'b1;
        own_d <= d;
        iso_bit <= !m_iso;
        @(posedge sys_clk);
        own_wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        if (!m_iso) m_own = d;
        chk_vec("owners", {2'h0, ~m_own, m_own}, {2'h0, npo, apo});
        chk_vec("isolation", 8'(m_iso), 8'(iso_on));
        @(posedge sys_clk);
        iso_bit <= m_iso;
    endtask
    task automatic fwrite(logic [1:0] lvl, bit c);
        @(posedge sys_clk);
        fwr <= 1'b1;
        flvl <= lvl;
        fcfg <= c;
        @(posedge sys_clk);
        fwr <= 1'b0;
        #1;
        chk_pair("flash write", !c && lvl != SIB_LVL_1 && m_stage < 2, fg, fd);
    endtask
    task automatic image(bit rb, int ver, bit au, bit ig);
        @(posedge sys_clk);
        img_rq <= 1'b1;
        rb_en <= rb;
        img_ver <= ver[15:0];
        auth <= au;
        integ <= ig;
        @(posedge sys_clk);
        img_rq <= 1'b0;
        #1;
        chk_pair("image", au && ig && (!rb || ver >= inst_ver), ia, ir);
    endtask
    task automatic xip(bit m);
        @(posedge sys_clk);
        xv <= 1'b1;
        xmode <= m;
        xaddr <= $urandom;
        xcip <= {$urandom, $urandom, $urandom, $urandom};
        key <= {$urandom, $urandom, $urandom, $urandom};
        @(posedge sys_clk);
        xv <= 1'b0;
        #1;
        chk_vec("fetch answer", 8'h01, 8'(xov));
    endtask
    // ----------
    // Sequence
    // ----------
    initial begin
        int v;
        v = $urandom(32'h8330);
        do_reset(1'b1, 1'b0, 3'h5);
        own_write(3'h2);
        access(1'b0, 1'b0, 1'b1, 16'h1000);
        access(1'b0, 1'b0, 1'b0, 16'h5000);
        access(1'b0, 1'b1, 1'b0, 16'h7F08);
        access(1'b0, 1'b1, 1'b0, 16'h7E10);
        access(1'b1, 1'b0, 1'b0, 16'h4000);
        repeat (16) begin
            v = $urandom_range(32'h0000_8FFF, 32'h0000_3000);
            access(v[0], v[1], v[2] & v[3], v[15:0]);
        end
        for (int l = 1; l < 4; l++)
            for (int c = 0; c < 2; c++)
                fwrite(l[1:0], c[0]);
        xip(SIB_MODE_XTS);
        xip(SIB_MODE_CTR);
        for (int k = 0; k < 16; k++)
            image(k[0], 255 + k % 3, k[1] | k[3], k[2] | k[3]);
        pulse(5);
        fwrite(2'h2, 1'b0);
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            pulse(5);
        end
        do_reset(1'b0, 1'b1, 3'h3);
        access(1'b0, 1'b0, 1'b0, 16'h5000);
        own_write(3'h6);
        fwrite(2'h3, 1'b0);
        v = $urandom_range(7, 1);
        @(posedge sys_clk);
        act <= v[2:0];
        @(posedge sys_clk);
        act <= 3'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_vec("programming session", 8'(v & -v), {5'h00, sess});
        pulse(5);
        pulse(5);
        close_out();
    end
    initial begin
        #500_000;
        bad_count++;
        close_out();
    end
endmodule // test_secure_isolation_boot_policy
`default_nettype wire
